/* hdl/tdc_pkg.sv */
package tdc_pkg;
   localparam int          NUM_CH        = 3;
   localparam int          FILT_LEN      = 3;
   localparam logic [3:0]  ADDR_CTRL0    = 4'h0;
   localparam logic [3:0]  ADDR_CTRL1    = 4'h1;
   localparam logic [3:0]  ADDR_CTRL2    = 4'h2;
   localparam logic [3:0]  ADDR_STATUS   = 4'h4;
   localparam logic [3:0]  ADDR_MASK     = 4'h5;
   localparam logic [3:0]  ADDR_LEVEL    = 4'h6;
   localparam int          BIT_GATE      = 0;
   localparam int          BIT_FILTER    = 1;
   localparam int          BIT_RISING    = 2;
   localparam int          BIT_WIPE      = 3;
   localparam int          BIT_CAP_EVT   = 4;
   localparam logic [4:0]  CTRL_RESET    = 5'h00;
   localparam logic [2:0]  MASK_RESET    = 3'h0;
endpackage

/* hdl/tdc_top.sv */
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module tdc_top (
   input  wire logic        CLOCK_I,
   input  wire logic        RST_I,
   input  wire logic [2:0]  CAPTURE_INPUT_PIN_I,
   input  wire logic [3:0]  ADDR_I,
   input  wire logic [7:0]  WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic      [7:0]  RDATA_O,
   output logic      [2:0]  CAPTURE_EVENT_O,
   output logic             BACKUP_WIPE_O,
   output logic             IRQ_O
);
   localparam int N = tdc_pkg::NUM_CH;
   localparam int F = tdc_pkg::FILT_LEN;

   logic [4:0]   ctrl_q [N];
   logic [N-1:0] mask_q;
   logic [N-1:0] status_q;
   logic [N-1:0] sync1_q, sync2_q, prev_q, raw_prev_q;
   logic [F-1:0] filt_q [N];
   logic [N-1:0] stable_q;
   logic [N-1:0] level_w, event_w, raw_edge_w, cap_d;
   logic [N-1:0] clr_w, wipe_sel_w;
   logic [7:0]   rdata_d;
   logic         wr_status_w, wr_mask_w;

   assign wr_status_w = WR_I && (ADDR_I == tdc_pkg::ADDR_STATUS);
   assign wr_mask_w   = WR_I && (ADDR_I == tdc_pkg::ADDR_MASK);
   assign clr_w       = wr_status_w ? WDATA_I[N-1:0] : '0;

   genvar g;
   for (g = 0; g < N; g++) begin : gen_ch
      logic sel_w;
      logic all1_w, all0_w;
      assign sel_w  = WR_I && (ADDR_I == 4'(g));
      assign all1_w = &filt_q[g];
      assign all0_w = ~|filt_q[g];
      // The filter only accepts a level held for FILT_LEN samples.
      assign level_w[g] = ctrl_q[g][tdc_pkg::BIT_FILTER] ? stable_q[g] : sync2_q[g];
      // Gate off masks the event itself, so no event edge is reported (raw pin edges still reach capture when BIT_CAP_EVT is clear); the level still follows the pin.
      assign event_w[g] = ctrl_q[g][tdc_pkg::BIT_GATE] &&
                          (ctrl_q[g][tdc_pkg::BIT_RISING] ? (level_w[g] && !prev_q[g])
                                                           : (!level_w[g] && prev_q[g]));
      assign raw_edge_w[g] = sync2_q[g] ^ raw_prev_q[g];
      assign cap_d[g] = ctrl_q[g][tdc_pkg::BIT_CAP_EVT] ? event_w[g] : raw_edge_w[g];
      assign wipe_sel_w[g] = ctrl_q[g][tdc_pkg::BIT_WIPE] && event_w[g];

      always_ff @(posedge CLOCK_I or posedge RST_I) begin
         if (RST_I) begin
            ctrl_q[g] <= tdc_pkg::CTRL_RESET;
         end else if (sel_w) begin
            ctrl_q[g] <= WDATA_I[4:0];
         end
      end

      always_ff @(posedge CLOCK_I or posedge RST_I) begin
         if (RST_I) begin
            filt_q[g]   <= '0;
            stable_q[g] <= 1'b0;
         end else begin
            filt_q[g] <= {filt_q[g][F-2:0], sync2_q[g]};
            if (all1_w) begin
               stable_q[g] <= 1'b1;
            end else if (all0_w) begin
               stable_q[g] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         prev_q     <= '0;
         raw_prev_q <= '0;
      end else begin
         sync1_q    <= CAPTURE_INPUT_PIN_I;
         sync2_q    <= sync1_q;
         prev_q     <= level_w;
         raw_prev_q <= sync2_q;
      end
   end

   // Set wins over a simultaneous write-one clear.
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clr_w) | event_w;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         mask_q <= tdc_pkg::MASK_RESET;
      end else if (wr_mask_w) begin
         mask_q <= WDATA_I[N-1:0];
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      unique case (ADDR_I)
         tdc_pkg::ADDR_CTRL0:  rdata_d = {3'h0, ctrl_q[0]};
         tdc_pkg::ADDR_CTRL1:  rdata_d = {3'h0, ctrl_q[1]};
         tdc_pkg::ADDR_CTRL2:  rdata_d = {3'h0, ctrl_q[2]};
         tdc_pkg::ADDR_STATUS: rdata_d = {5'h00, status_q};
         tdc_pkg::ADDR_MASK:   rdata_d = {5'h00, mask_q};
         tdc_pkg::ADDR_LEVEL:  rdata_d = {5'h00, sync2_q};
         default:              rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O         <= 8'h00;
         CAPTURE_EVENT_O <= '0;
         BACKUP_WIPE_O   <= 1'b0;
         IRQ_O           <= 1'b0;
      end else begin
         RDATA_O         <= RD_I ? rdata_d : 8'h00;
         CAPTURE_EVENT_O <= cap_d;
         BACKUP_WIPE_O   <= |wipe_sel_w;
         // Registered, so IRQ lags status by one cycle.
         IRQ_O           <= |(status_q & mask_q);
      end
   end

   a_wipe_follows_event: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (|wipe_sel_w) |=> BACKUP_WIPE_O) else $error("wipe pulse missing");
   a_no_wipe_unsel: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      BACKUP_WIPE_O |-> $past(|wipe_sel_w)) else $error("spurious wipe");
   a_cap_source: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (!ctrl_q[0][tdc_pkg::BIT_CAP_EVT] && raw_edge_w[0]) |=> CAPTURE_EVENT_O[0]) else $error("pin capture lost");
   a_gate_blocks: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      !ctrl_q[1][tdc_pkg::BIT_GATE] |-> !event_w[1]) else $error("gated channel fired");
   a_edge_rising: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (event_w[0] && ctrl_q[0][tdc_pkg::BIT_RISING]) |-> level_w[0]) else $error("wrong edge");
   a_event_single: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      event_w[2] |=> !event_w[2]) else $error("event longer than one cycle");
   a_status_sets: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      event_w[0] |=> status_q[0]) else $error("status not set");
   a_irq_masked: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (status_q == 3'h0 || mask_q == 3'h0) |=> !IRQ_O) else $error("irq while masked");
   a_filter_delay: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (ctrl_q[0][tdc_pkg::BIT_FILTER] && event_w[0]) |-> (stable_q[0] != $past(stable_q[0]))) else $error("filter bypassed");

   // The per-channel checks below are identical for every channel.
   // They watch the internal event, not the pin, so they stay valid
   // whatever the switch in front of the pin does.
   for (g = 0; g < N; g++) begin : gen_chk

      a_gate_quiet: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         !ctrl_q[g][tdc_pkg::BIT_GATE] |-> !event_w[g])
         else $error("gated channel produced an event");

      a_edge_falling: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         (event_w[g] && !ctrl_q[g][tdc_pkg::BIT_RISING]) |-> !level_w[g])
         else $error("falling mode fired on a rising edge");

      a_cap_from_event: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         (ctrl_q[g][tdc_pkg::BIT_CAP_EVT] && event_w[g]) |=> CAPTURE_EVENT_O[g])
         else $error("capture from intrusion lost");

      a_cap_no_stray: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         CAPTURE_EVENT_O[g] |-> $past(cap_d[g]))
         else $error("capture pulse without a source");

      a_status_holds: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         (status_q[g] && !clr_w[g]) |=> status_q[g])
         else $error("status lost without a clear");

      a_status_clears: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         (clr_w[g] && !event_w[g]) |=> !status_q[g])
         else $error("status survived a clear");

      a_ctrl_write: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         (WR_I && (ADDR_I == 4'(g))) |=> (ctrl_q[g] == $past(WDATA_I[4:0])))
         else $error("channel setting not taken");

      a_irq_raise: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         (status_q[g] && mask_q[g]) |=> IRQ_O)
         else $error("enabled status gave no interrupt");

      a_wipe_enabled: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         (ctrl_q[g][tdc_pkg::BIT_WIPE] && event_w[g]) |=> BACKUP_WIPE_O)
         else $error("enabled wipe missing");

      a_filter_rise: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         $rose(stable_q[g]) |-> $past(&filt_q[g]))
         else $error("filter rose on a short pulse");

      a_filter_fall: assert property (@(posedge CLOCK_I) disable iff (RST_I)
         $fell(stable_q[g]) |-> $past(~|filt_q[g]))
         else $error("filter fell on a short pulse");

   end

   c_wipe: cover property (@(posedge CLOCK_I) BACKUP_WIPE_O);
   c_status_clear: cover property (@(posedge CLOCK_I) clr_w[0] && status_q[0]);
   c_filter_event: cover property (@(posedge CLOCK_I) event_w[0] && ctrl_q[0][tdc_pkg::BIT_FILTER]);
   c_irq: cover property (@(posedge CLOCK_I) IRQ_O);
   c_cap_evt: cover property (@(posedge CLOCK_I) CAPTURE_EVENT_O[1] && ctrl_q[1][tdc_pkg::BIT_CAP_EVT]);
endmodule
`default_nettype wire

/* sim/tdc_switch_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tdc_switch_model (
   input  wire logic       clk_i,
   input  wire logic [2:0] level_i,
   output logic      [2:0] pin_o
);
   // A contact changes a cycle after it is moved, on the same rising edge that the detector samples on.
   always_ff @(posedge clk_i) pin_o <= level_i;
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wipe, irq;
   logic [2:0] lvl = 3'h0, pin, cap;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, ncap, nwipe;
   int         err_total = 0, samples_checked = 0;
   initial forever #50 clk = ~clk;
   tdc_switch_model sw_u (.clk_i(clk), .level_i(lvl), .pin_o(pin));
   tdc_top dut_u (.CLOCK_I(clk), .RST_I(rst), .CAPTURE_INPUT_PIN_I(pin), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CAPTURE_EVENT_O(cap), .BACKUP_WIPE_O(wipe), .IRQ_O(irq));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Moves the pins to l, returns them to b after h cycles, and counts pulses of channel c.
   task automatic stim(input logic [2:0] l, input logic [2:0] b, input int h, input int c);
      ncap = 8'h00;
      nwipe = 8'h00;
      @(posedge clk);
      lvl <= l;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         if (i == h) lvl <= b;
         if (cap[c] === 1'b1) ncap++;
         if (wipe === 1'b1) nwipe++;
      end
   endtask
   task automatic t_reset();
      rd_chk(tdc_pkg::ADDR_CTRL0, 8'h00);
      rd_chk(tdc_pkg::ADDR_MASK, 8'h00);
      rd_chk(4'h3, 8'h00);
      chk({7'h00, irq}, 8'h00);
   endtask
   task automatic t_intrusion();
      wr_reg(tdc_pkg::ADDR_CTRL0, 8'h1d);
      // Only the enable is set; priority lives in the interrupt controller.
      wr_reg(tdc_pkg::ADDR_MASK, 8'h01);
      stim(3'h1, 3'h1, 99, 0);
      chk(ncap, 8'h01);
      chk(nwipe, 8'h01);
      rd_chk(tdc_pkg::ADDR_STATUS, 8'h01);
      chk({7'h00, irq}, 8'h01);
      stim(3'h0, 3'h0, 99, 0);
      chk(ncap, 8'h00);
      wr_reg(tdc_pkg::ADDR_STATUS, 8'h01);
      rd_chk(tdc_pkg::ADDR_STATUS, 8'h00);
      chk({7'h00, irq}, 8'h00);
   endtask
   task automatic t_gate();
      wr_reg(tdc_pkg::ADDR_CTRL1, 8'h11);
      stim(3'h2, 3'h2, 99, 1);
      chk(ncap, 8'h00);
      stim(3'h0, 3'h0, 99, 1);
      chk(ncap + nwipe, 8'h01);
      chk({7'h00, irq}, 8'h00);
      wr_reg(tdc_pkg::ADDR_CTRL1, 8'h10);
      rd_chk(tdc_pkg::ADDR_CTRL1, 8'h10);
      wr_reg(tdc_pkg::ADDR_STATUS, 8'h02);
      stim(3'h2, 3'h0, 3, 1);
      chk(ncap, 8'h00);
      rd_chk(tdc_pkg::ADDR_STATUS, 8'h00);
   endtask
   task automatic t_pin_filter();
      wr_reg(tdc_pkg::ADDR_CTRL2, 8'h00);
      stim(3'h4, 3'h4, 99, 2);
      chk(ncap + nwipe, 8'h01);
      wr_reg(tdc_pkg::ADDR_CTRL0, 8'h1f);
      stim(3'h5, 3'h4, 1, 0);
      chk(ncap, 8'h00);
      stim(3'h5, 3'h5, 99, 0);
      chk(ncap, 8'h01);
      rd_chk(tdc_pkg::ADDR_LEVEL, 8'h05);
   endtask
   task automatic close_out();
      $display("Mismatches %0d of %0d checks", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #1000000;
      err_total++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_intrusion();
      t_gate();
      t_pin_filter();
      close_out();
   end
endmodule
`default_nettype wire
